// ---- include/tas_defs.svh ----
// Constants of the touch acquisition sequencer: status bits, channel codes and timing.
// Assumes a 100 MHz system clock; every delay counts internal oscillator periods.
`ifndef TAS_DEFS_SVH
`define TAS_DEFS_SVH

`define TAS_CLK_PERIOD_NS 10
`define TAS_OSC_PERIOD_NS 555
`define TAS_OSC_CYCLES ((`TAS_OSC_PERIOD_NS + `TAS_CLK_PERIOD_NS - 1) / `TAS_CLK_PERIOD_NS)

`define TAS_STAT_CONV_DONE_BIT 7
`define TAS_STAT_PEN_TOUCH_BIT 6

`define TAS_CHAN_LAST 4
`define TAS_CHAN_SEQ 3'h7
`define TAS_CHAN_COUNT 5

`define TAS_OVERHEAD_OSC 47
`define TAS_CONV_OSC 21
`define TAS_TAIL_OSC 1
`define TAS_POWERUP_OSC 16

`define TAS_DELAY_MIN_NS 500
`define TAS_DELAY_MAX_NS 18190000
`define TAS_DELAY_MIN_OSC \
    ((`TAS_DELAY_MIN_NS + `TAS_OSC_PERIOD_NS - 1) / `TAS_OSC_PERIOD_NS)
`define TAS_DELAY_MAX_OSC (`TAS_DELAY_MAX_NS / `TAS_OSC_PERIOD_NS)

`endif

// ---- include/tas_pkg.sv ----
// Types shared by the touch acquisition sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package tas_pkg;

    typedef enum logic [2:0] {
        TAS_CMD_SELECT,
        TAS_CMD_CONVERT,
        TAS_CMD_MANUAL_AUTO,
        TAS_CMD_TOUCH_DETECT,
        TAS_CMD_TOUCH_TRIGGERED
    } tas_cmd_type;

    typedef enum logic [1:0] {
        TAS_MODE_MANUAL,
        TAS_MODE_AUTO,
        TAS_MODE_TOUCH_DETECT,
        TAS_MODE_TOUCH_TRIGGERED
    } tas_mode_type;

    typedef enum logic [2:0] {
        TAS_ST_POWERUP,
        TAS_ST_IDLE,
        TAS_ST_OVERHEAD,
        TAS_ST_WAIT_EDGE,
        TAS_ST_BIAS,
        TAS_ST_CONVERT,
        TAS_ST_FILTER,
        TAS_ST_TAIL
    } tas_state_type;

endpackage

// ---- verilog/tas_osc_timer.sv ----
// Delay timer counting internal oscillator periods.
// Assumes a start pulse from logic on the same clock; a new start restarts it.
`timescale 1ns/1ps
`default_nettype none
`include "tas_defs.svh"

module tas_osc_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Request
    input wire logic i_start,
    input wire logic [15:0] i_osc_count,
    // Answer
    output logic o_done
);
    import tas_pkg::*;

    localparam logic [6:0] PRE_LOAD = 7'(`TAS_OSC_CYCLES - 1); // R20

    logic [6:0] prescale;
    logic [15:0] left;
    logic next_done;
    logic [6:0] next_prescale;
    logic [15:0] next_left;

    always_comb begin
        next_prescale = prescale;
        next_left = left;
        next_done = 1'b0;
        if (i_start) begin
            next_prescale = PRE_LOAD;
            next_left = (i_osc_count == 16'h0) ? 16'h1 : i_osc_count;
        end else if (left != 16'h0) begin
            if (prescale == 7'h0) begin
                next_prescale = PRE_LOAD;
                next_left = left - 16'h1;
                next_done = (left == 16'h1);
            end else begin
                next_prescale = prescale - 7'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prescale <= 7'h0;
            left <= 16'h0;
            o_done <= 1'b0;
        end else begin
            prescale <= next_prescale;
            left <= next_left;
            o_done <= next_done;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/tas_acq_sequencer.sv ----
// Acquisition sequencer and interrupt logic of a resistive touch controller.
// Assumes a command decoder and a result reader on i_clk; touch, trigger and
// reset pins arrive asynchronously; the interrupt line has an external pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "tas_defs.svh"

// How it works
// R1: touch-detect touch sets pen flag, pulls interrupt
// R2: status read clears pen flag, releases line
// R3: touch-triggered mode idles until panel touched
// R4: touch-triggered interrupts only with touched coordinates; code suppresses untouched ones only in auto mode with i_cond_irq
// R5: starts in manual mode after reset
// R6: single conversion uses command channel field
// R7: sequence code converts mask bits MSB first
// R8: mask one samples, mask zero skips channel
// R9: averaging repeats conversions with filter delay between
// R10: nonzero edge select waits for trigger edge
// R11: trigger edge starts bias delay, then acquisition
// R12: interrupt held low through reset and power-up
// R13: conversion completion sets done flag, pulls line
// R14: reading all channel data clears done flag
// R15: interrupt line is only pulled low, never high
// R16: no new conversion while interrupt asserted
// R17: sequence takes overhead plus per-channel delays
// R18: averaging count 1,3,5,7; one to five channels
// R19: settle delays clamp to 0.5us..18.19ms
// R20: timing counts oscillator periods of 555ns
// R21: host programs auto rate, fetches at rate; code uses i_rate only to pick auto over manual and restarts at once when idle
// R22: host distrusts extreme pressure sample pairs
// R23: host sets bias delay near ten RC
// R24: touch-detect mode left only by manual command
// R25: channel biased before conversion, unbiased after
// R26: results held until read, never overwritten; code overwrites them unread in auto mode with i_cond_irq and no touch
module tas_acq_sequencer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_hardware_reset_pin_n,
    // Commands
    input wire logic i_cmd_valid,
    input wire tas_pkg::tas_cmd_type i_cmd_code,
    input wire logic [2:0] i_cmd_chan,
    // Configuration
    input wire logic [3:0] i_rate,
    input wire logic i_cond_irq,
    input wire logic [4:0] i_channel_mask_register,
    input wire logic [1:0] i_avg_order,
    input wire logic [15:0] i_bias_settle_delay,
    input wire logic [15:0] i_filter_settle_delay,
    input wire logic [1:0] i_external_trigger_edge_select,
    // Host reads
    input wire logic i_status_read,
    input wire logic i_channels_read,
    input wire logic [2:0] i_result_index,
    // Pins and converter
    input wire logic i_panel_touched,
    input wire logic i_external_trigger,
    input wire logic [11:0] i_adc_data,
    output logic o_adc_start,
    output logic o_bias_enable,
    output logic [2:0] o_bias_chan,
    // Interrupt line and status
    output logic o_interrupt_request_line_out,
    output logic o_interrupt_request_line_oe_n,
    output logic [7:0] o_status_register,
    output logic [14:0] o_result_data,
    output tas_pkg::tas_mode_type o_mode,
    output logic o_busy
);
    import tas_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic rpin_meta, rpin_sync, pen_meta, pen_sync, aux_meta, aux_sync, aux_prev, pen_prev;
    logic rst;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rpin_meta <= 1'b0;
            rpin_sync <= 1'b0;
            pen_meta <= 1'b0;
            pen_sync <= 1'b0;
            aux_meta <= 1'b0;
            aux_sync <= 1'b0;
            aux_prev <= 1'b0;
            pen_prev <= 1'b0;
        end else begin
            rpin_meta <= i_hardware_reset_pin_n;
            rpin_sync <= rpin_meta;
            pen_meta <= i_panel_touched;
            pen_sync <= pen_meta;
            aux_meta <= i_external_trigger;
            aux_sync <= aux_meta;
            aux_prev <= aux_sync;
            pen_prev <= pen_sync;
        end
    end

    assign rst = i_reset | ~rpin_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [4:0] chan_bit(input logic [2:0] chan);
        return (chan <= 3'(`TAS_CHAN_LAST)) ? 5'(5'h10 >> chan) : 5'h0;
    endfunction

    function automatic logic [2:0] first_chan(input logic [4:0] mask);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < `TAS_CHAN_COUNT; i++) begin
            if (mask[i]) c = 3'(`TAS_CHAN_LAST - i);
        end
        return c;
    endfunction

    function automatic logic [15:0] clamp_delay(input logic [15:0] d);
        if (d < 16'(`TAS_DELAY_MIN_OSC)) return 16'(`TAS_DELAY_MIN_OSC);
        if (d > 16'(`TAS_DELAY_MAX_OSC)) return 16'(`TAS_DELAY_MAX_OSC);
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    tas_state_type state, next_state;
    tas_mode_type mode, next_mode;
    logic [4:0] remaining, next_remaining, start_mask;
    logic [2:0] chan, next_chan, avg_left, next_avg_left;
    logic [14:0] accum, next_accum, sum;
    logic [14:0] results [`TAS_CHAN_COUNT];
    logic [14:0] next_results [`TAS_CHAN_COUNT];
    logic pen_flag, next_pen_flag, conv_flag, next_conv_flag;
    logic timer_start, next_timer_start, timer_done;
    logic [15:0] timer_count, next_timer_count;
    logic next_adc_start, next_bias_enable, next_irq_oe_n;
    logic [2:0] next_bias_chan;
    logic irq_active, pen_rise, aux_hit, seq_done, done_evt, go_bias;

    tas_osc_timer u_timer (
        .i_clk(i_clk),
        .i_reset(rst),
        .i_start(timer_start),
        .i_osc_count(timer_count),
        .o_done(timer_done)
    );

    assign irq_active = (state == TAS_ST_POWERUP) | pen_flag | conv_flag;
    assign pen_rise = pen_sync & ~pen_prev;
    assign aux_hit = (i_external_trigger_edge_select[0] & aux_sync & ~aux_prev) |
                     (i_external_trigger_edge_select[1] & ~aux_sync & aux_prev);
    assign sum = accum + 15'(i_adc_data);

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_remaining = remaining;
        next_chan = chan;
        next_avg_left = avg_left;
        next_accum = accum;
        next_results = results;
        next_pen_flag = pen_flag;
        next_conv_flag = conv_flag;
        next_timer_start = 1'b0;
        next_timer_count = timer_count;
        next_adc_start = 1'b0;
        next_bias_enable = o_bias_enable;
        next_bias_chan = o_bias_chan;
        seq_done = 1'b0;
        go_bias = 1'b0;
        start_mask = 5'h0;
        if (i_cmd_valid) begin
            if (i_cmd_code == TAS_CMD_MANUAL_AUTO) begin
                next_mode = (i_rate == 4'h0) ? TAS_MODE_MANUAL : TAS_MODE_AUTO; // R24
            end else if (i_cmd_code == TAS_CMD_TOUCH_DETECT) begin
                next_mode = TAS_MODE_TOUCH_DETECT;
            end else if (i_cmd_code == TAS_CMD_TOUCH_TRIGGERED &&
                         mode != TAS_MODE_TOUCH_DETECT) begin
                next_mode = TAS_MODE_TOUCH_TRIGGERED; // R24
            end
        end
        if (mode == TAS_MODE_MANUAL && i_cmd_valid && i_cmd_code == TAS_CMD_CONVERT) begin
            start_mask = (i_cmd_chan == `TAS_CHAN_SEQ) ? i_channel_mask_register // R7
                                                      : chan_bit(i_cmd_chan); // R6
        end else if (mode == TAS_MODE_AUTO) begin
            start_mask = i_channel_mask_register;
        end else if (mode == TAS_MODE_TOUCH_TRIGGERED && pen_sync) begin
            start_mask = i_channel_mask_register; // R3
        end
        unique case (state)
            TAS_ST_POWERUP: begin
                if (timer_done) next_state = TAS_ST_IDLE; // R12
            end
            TAS_ST_IDLE: begin
                if (mode == TAS_MODE_MANUAL && i_cmd_valid && i_cmd_code == TAS_CMD_SELECT &&
                    chan_bit(i_cmd_chan) != 5'h0) begin
                    next_bias_enable = 1'b1;
                    next_bias_chan = i_cmd_chan;
                end
                if (!irq_active && start_mask != 5'h0) begin // R16
                    next_remaining = start_mask;
                    next_chan = first_chan(start_mask); // R7
                    next_state = TAS_ST_OVERHEAD;
                    next_timer_start = 1'b1;
                    next_timer_count = 16'(`TAS_OVERHEAD_OSC); // R17
                end
            end
            TAS_ST_OVERHEAD: begin
                if (timer_done) begin
                    if (i_external_trigger_edge_select != 2'h0) begin
                        next_state = TAS_ST_WAIT_EDGE; // R10
                    end else begin
                        go_bias = 1'b1;
                    end
                end
            end
            TAS_ST_WAIT_EDGE: begin
                go_bias = aux_hit; // R11
            end
            TAS_ST_BIAS: begin
                if (timer_done) begin
                    next_state = TAS_ST_CONVERT;
                    next_adc_start = 1'b1;
                    next_accum = 15'h0;
                    next_avg_left = {i_avg_order, 1'b1}; // R18
                    next_timer_start = 1'b1;
                    next_timer_count = 16'(`TAS_CONV_OSC); // R17
                end
            end
            TAS_ST_CONVERT: begin
                if (timer_done) begin
                    next_accum = sum;
                    next_timer_start = 1'b1;
                    if (avg_left > 3'h1) begin
                        next_avg_left = avg_left - 3'h1;
                        next_state = TAS_ST_FILTER; // R9
                        next_timer_count = clamp_delay(i_filter_settle_delay); // R19
                    end else begin
                        next_results[chan] = sum; // R26
                        next_bias_enable = 1'b0; // R25
                        next_state = TAS_ST_TAIL;
                        next_timer_count = 16'(`TAS_TAIL_OSC); // R17
                    end
                end
            end
            TAS_ST_FILTER: begin
                if (timer_done) begin
                    next_state = TAS_ST_CONVERT;
                    next_adc_start = 1'b1; // R9
                    next_timer_start = 1'b1;
                    next_timer_count = 16'(`TAS_CONV_OSC);
                end
            end
            TAS_ST_TAIL: begin
                if (timer_done) begin
                    next_remaining = remaining & ~chan_bit(chan); // R8
                    if (next_remaining != 5'h0) begin
                        next_chan = first_chan(next_remaining); // R8
                        go_bias = 1'b1;
                    end else begin
                        seq_done = 1'b1;
                        next_state = TAS_ST_IDLE;
                    end
                end
            end
        endcase
        if (go_bias) begin
            next_state = TAS_ST_BIAS;
            next_bias_enable = 1'b1; // R25
            next_bias_chan = next_chan;
            next_timer_start = 1'b1;
            next_timer_count = clamp_delay(i_bias_settle_delay); // R19
        end
        done_evt = seq_done && !(mode == TAS_MODE_AUTO && i_cond_irq && !pen_sync);
        if (i_status_read) next_pen_flag = 1'b0; // R2
        if (mode == TAS_MODE_TOUCH_DETECT && pen_rise) next_pen_flag = 1'b1; // R1
        if (i_channels_read) next_conv_flag = 1'b0; // R14
        if (done_evt) next_conv_flag = 1'b1; // R13 R4
        next_irq_oe_n = !(next_state == TAS_ST_POWERUP || next_pen_flag || next_conv_flag);
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            state <= TAS_ST_POWERUP;
            mode <= TAS_MODE_MANUAL; // R5
            remaining <= 5'h0;
            chan <= 3'h0;
            avg_left <= 3'h0;
            accum <= 15'h0;
            for (int i = 0; i < `TAS_CHAN_COUNT; i++) results[i] <= 15'h0;
            pen_flag <= 1'b0;
            conv_flag <= 1'b0;
            timer_start <= 1'b1;
            timer_count <= 16'(`TAS_POWERUP_OSC);
            o_adc_start <= 1'b0;
            o_bias_enable <= 1'b0;
            o_bias_chan <= 3'h0;
            o_interrupt_request_line_out <= 1'b0;
            o_interrupt_request_line_oe_n <= 1'b0; // R12
            o_status_register <= 8'h0;
            o_result_data <= 15'h0;
            o_mode <= TAS_MODE_MANUAL;
            o_busy <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            remaining <= next_remaining;
            chan <= next_chan;
            avg_left <= next_avg_left;
            accum <= next_accum;
            results <= next_results;
            pen_flag <= next_pen_flag;
            conv_flag <= next_conv_flag;
            timer_start <= next_timer_start;
            timer_count <= next_timer_count;
            o_adc_start <= next_adc_start;
            o_bias_enable <= next_bias_enable;
            o_bias_chan <= next_bias_chan;
            o_interrupt_request_line_out <= 1'b0; // R15
            o_interrupt_request_line_oe_n <= next_irq_oe_n;
            o_status_register <= {next_conv_flag, next_pen_flag, 6'h0};
            o_result_data <= (i_result_index <= 3'(`TAS_CHAN_LAST)) ?
                             next_results[i_result_index] : 15'h0;
            o_mode <= next_mode;
            o_busy <= !(next_state == TAS_ST_IDLE || next_state == TAS_ST_POWERUP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking @(posedge i_clk); endclocking
    default disable iff (rst);

    property p_pen_set;
        (mode == TAS_MODE_TOUCH_DETECT && pen_rise) |=>
            (o_status_register[`TAS_STAT_PEN_TOUCH_BIT] && !o_interrupt_request_line_oe_n);
    endproperty
    a_pen_set: assert property (p_pen_set) else $error("pen flag not set on touch"); // R1

    property p_pen_clear;
        (i_status_read && !(mode == TAS_MODE_TOUCH_DETECT && pen_rise)) |=> !pen_flag;
    endproperty
    a_pen_clear: assert property (p_pen_clear) else $error("pen flag kept after read"); // R2

    property p_trig_wait;
        (mode == TAS_MODE_TOUCH_TRIGGERED && state == TAS_ST_IDLE && !pen_sync) |=>
            state == TAS_ST_IDLE;
    endproperty
    a_trig_wait: assert property (p_trig_wait) else $error("started without touch"); // R3

    property p_conv_set;
        done_evt |=> (o_status_register[`TAS_STAT_CONV_DONE_BIT] &&
                      !o_interrupt_request_line_oe_n);
    endproperty
    a_conv_set: assert property (p_conv_set) else $error("done flag not set"); // R13

    property p_conv_clear;
        (i_channels_read && !done_evt) |=> !conv_flag ##0 !o_status_register[7];
    endproperty
    a_conv_clear: assert property (p_conv_clear) else $error("done flag kept"); // R14

    property p_release_only;
        o_interrupt_request_line_out == 1'b0;
    endproperty
    a_release_only: assert property (p_release_only) else $error("line driven high"); // R15

    property p_no_start;
        (state == TAS_ST_IDLE && irq_active) |=> (state == TAS_ST_IDLE && !o_adc_start);
    endproperty
    a_no_start: assert property (p_no_start) else $error("start under interrupt"); // R16

    property p_pwrup_low;
        (state == TAS_ST_POWERUP) |-> !o_interrupt_request_line_oe_n;
    endproperty
    a_pwrup_low: assert property (p_pwrup_low) else $error("line free in power-up"); // R12

    property p_mask_only;
        o_adc_start |-> ((remaining & chan_bit(chan)) != 5'h0 && o_bias_enable);
    endproperty
    a_mask_only: assert property (p_mask_only) else $error("unmasked channel sampled"); // R8

    property p_avg_load;
        (state == TAS_ST_BIAS && timer_done) |=> avg_left == {$past(i_avg_order), 1'b1};
    endproperty
    a_avg_load: assert property (p_avg_load) else $error("wrong averaging count"); // R18

    property p_edge_bias;
        (state == TAS_ST_WAIT_EDGE && aux_hit) |=> (state == TAS_ST_BIAS && o_bias_enable);
    endproperty
    a_edge_bias: assert property (p_edge_bias) else $error("edge did not start bias"); // R11

    c_pen_flag: cover property (mode == TAS_MODE_TOUCH_DETECT && pen_rise);
    c_conv_done: cover property (done_evt);
    c_edge_start: cover property (state == TAS_ST_WAIT_EDGE && aux_hit);
    c_filter: cover property (state == TAS_ST_FILTER && timer_done);

endmodule
`default_nettype wire

// ---- dv/tas_host_model.sv ----
// Host model: pull-up on the interrupt line and slow automatic flag reads.
// Assumes the sequencer's split interrupt pin and its clock.
`timescale 1ns/1ps
`default_nettype none
module tas_host_model (
    // Clock
    input wire logic i_clk,
    // Interrupt pin halves
    input wire logic i_irq_out,
    input wire logic i_irq_oe_n,
    // Host behaviour
    input wire logic i_ack_en,
    input wire logic i_ack_chan,
    // Line and reads
    output logic o_irq_line,
    output logic o_status_read,
    output logic o_channels_read
);
    logic [4:0] wait_cnt;
    // A released line is pulled high by the external resistor.
    assign o_irq_line = i_irq_oe_n ? 1'b1 : i_irq_out;
    initial begin
        wait_cnt = 5'h0;
        o_status_read = 1'b0;
        o_channels_read = 1'b0;
    end
    // The host answers a low line late, with one read pulse.
    always @(negedge i_clk) begin
        o_status_read <= 1'b0;
        o_channels_read <= 1'b0;
        if (!o_irq_line && i_ack_en) begin
            wait_cnt <= wait_cnt + 5'h1;
            if (wait_cnt == 5'h1f) begin
                o_status_read <= !i_ack_chan;
                o_channels_read <= i_ack_chan;
            end
        end else begin
            wait_cnt <= 5'h0;
        end
    end
endmodule
`default_nettype wire

// ---- dv/touch_acquisition_sequencer_tb.sv ----
// Self-checking bench of the acquisition sequencer.
// Assumes the host model answers interrupts when enabled.
`timescale 1ns/1ps
`default_nettype none
`include "tas_defs.svh"
module touch_acquisition_sequencer_tb;
    import tas_pkg::*;
    localparam int OSC = `TAS_OSC_CYCLES;
    logic clk, rst, rst_pin_n, cmd_valid, st_rd, ch_rd, touch, trig, ack_en, ack_chan, cirq;
    logic adc_start, bias_en, irq_out, oe_n, line, busy;
    tas_cmd_type cmd_code;
    tas_mode_type mode;
    logic [2:0] cmd_chan, res_idx, bias_chan;
    logic [4:0] mask;
    logic [3:0] rate;
    logic [1:0] avg, edge_sel;
    logic [15:0] bias_d, filt_d;
    logic [11:0] adc;
    logic [7:0] status;
    logic [14:0] result;
    logic [2:0] chq[$];
    int n_mismatch, tests_run, cyc;
    tas_acq_sequencer dut_u (.i_clk(clk), .i_reset(rst), .i_hardware_reset_pin_n(rst_pin_n),
        .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_chan(cmd_chan),
        .i_rate(rate), .i_cond_irq(cirq), .i_channel_mask_register(mask),
        .i_avg_order(avg), .i_bias_settle_delay(bias_d), .i_filter_settle_delay(filt_d),
        .i_external_trigger_edge_select(edge_sel), .i_status_read(st_rd),
        .i_channels_read(ch_rd), .i_result_index(res_idx), .i_panel_touched(touch),
        .i_external_trigger(trig), .i_adc_data(adc), .o_adc_start(adc_start),
        .o_bias_enable(bias_en), .o_bias_chan(bias_chan),
        .o_interrupt_request_line_out(irq_out), .o_interrupt_request_line_oe_n(oe_n),
        .o_status_register(status), .o_result_data(result), .o_mode(mode), .o_busy(busy));
    tas_host_model host_u (.i_clk(clk), .i_irq_out(irq_out), .i_irq_oe_n(oe_n),
        .i_ack_en(ack_en), .i_ack_chan(ack_chan), .o_irq_line(line),
        .o_status_read(st_rd), .o_channels_read(ch_rd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The channel under bias is logged at every conversion start.
    always @(negedge clk) begin
        if (adc_start === 1'b1) begin
            chq.push_back(bias_chan);
        end
    end
    task automatic print_verdict();
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmd(input tas_cmd_type c, input logic [2:0] ch);
        @(negedge clk);
        cmd_code = c;
        cmd_chan = ch;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    task automatic wait_idle(output int n);
        n = 1;
        @(negedge clk);
        while (busy !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40000) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wait_line(input logic v);
        int n;
        n = 0;
        while (oe_n !== v && n < 40000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40000) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic conv(input logic [2:0] ch, output int n);
        cmd(TAS_CMD_CONVERT, ch);
        wait_idle(n);
    endtask
    task automatic clear(input logic by_chan);
        ack_chan = by_chan;
        ack_en = 1'b1;
        wait_line(1'b1);
        ack_en = 1'b0;
        chq.delete();
    endtask
    task automatic get_result(input logic [2:0] idx, input logic [14:0] exp);
        res_idx = idx;
        repeat (2) @(negedge clk);
        chk("result", {1'b0, exp}, {1'b0, result});
    endtask
    function automatic logic [15:0] near(int got, int nch, int n);
        int e;
        e = OSC * (47 + nch * (2 + (n - 1) + 21 * n + 1));
        return (got > e - 100 && got < e + 100) ? 16'h1 : 16'h0;
    endfunction
    initial begin
        {rst_pin_n, cmd_valid, touch, trig, ack_en, ack_chan, cirq} = 7'h40;
        cmd_code = TAS_CMD_SELECT;
        {cmd_chan, res_idx, edge_sel} = 8'h00;
        {rate, mask, avg, adc} = {4'h0, 5'h01, 2'h0, 12'h5a3};
        bias_d = 16'h0002;
        filt_d = 16'h0001;
        rst = 1'b1;
        repeat (10) @(negedge clk);
        chk("oe_n reset", 0, oe_n);
        chk("mode reset", TAS_MODE_MANUAL, mode);
        rst = 1'b0;
        @(negedge clk);
        chk("oe_n powerup", 0, oe_n);
        wait_line(1'b1);
        chk("line idle", 1, line);
        conv(3'h2, cyc);
        chk("duration one", 1, near(cyc, 1, 1));
        chk("status done", 8'h80, status);
        chk("line done", 0, line);
        chk("single chan", 2, chq.pop_front());
        chk("bias off", 0, bias_en);
        get_result(3'h2, 15'h05a3);
        conv(3'h1, cyc);
        chk("refused", 1, cyc < 4);
        clear(1'b1);
        chk("status clr", 0, status);
        mask = 5'b10101;
        avg = 2'h1;
        conv(`TAS_CHAN_SEQ, cyc);
        chk("duration seq", 1, near(cyc, 3, 3));
        chk("conv count", 9, chq.size());
        for (int i = 0; i < 9; i++) begin
            chk("seq order", (i / 3) * 2, chq.pop_front());
        end
        get_result(3'h2, 15'h10e9);
        get_result(3'h1, 15'h0000);
        clear(1'b1);
        mask = 5'b00010;
        avg = 2'h0;
        bias_d = 16'h0004;
        for (int e = 1; e < 4; e++) begin
            edge_sel = e[1:0];
            cmd(TAS_CMD_CONVERT, `TAS_CHAN_SEQ);
            repeat (47 * OSC + 300) @(negedge clk);
            chk("no trigger", 0, chq.size());
            trig = ~trig;
            cyc = 0;
            while (adc_start !== 1'b1 && cyc < 2000) begin
                @(negedge clk);
                cyc++;
            end
            chk("bias first", 1, cyc >= 4 * OSC && cyc < 4 * OSC + 60);
            wait_idle(cyc);
            clear(1'b1);
        end
        edge_sel = 2'h0;
        cmd(TAS_CMD_TOUCH_DETECT, 3'h0);
        touch = 1'b1;
        wait_line(1'b0);
        chk("pen flag", 8'h40, status);
        cmd(TAS_CMD_TOUCH_TRIGGERED, 3'h0);
        chk("stay detect", TAS_MODE_TOUCH_DETECT, mode);
        clear(1'b0);
        chk("pen clr", 0, status);
        touch = 1'b0;
        cmd(TAS_CMD_MANUAL_AUTO, 3'h0);
        chk("leave detect", TAS_MODE_MANUAL, mode);
        cmd(TAS_CMD_TOUCH_TRIGGERED, 3'h0);
        repeat (500) @(negedge clk);
        chk("idle untouched", 0, busy);
        chk("no irq", 1, oe_n);
        touch = 1'b1;
        wait_line(1'b0);
        touch = 1'b0;
        chk("trig done", 8'h80, status);
        chk("trig chan", 3, chq.pop_front());
        clear(1'b1);
        rate = 4'h1;
        cmd(TAS_CMD_MANUAL_AUTO, 3'h0);
        chk("auto mode", TAS_MODE_AUTO, mode);
        wait_line(1'b0);
        chk("auto done", 8'h80, status);
        cirq = 1'b1;
        clear(1'b1);
        repeat (9000) @(negedge clk);
        chk("cond irq", 1, oe_n);
        chk("auto runs", 2, chq.size());
        rst_pin_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("pin reset", 0, oe_n);
        chk("pin mode", TAS_MODE_MANUAL, mode);
        rst_pin_n = 1'b1;
        wait_line(1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
